// [src/srap_pkg.sv]
// Shared constants and types of the serial register access port
package srap_pkg;
	// ==========================================
	// I2C slave addresses by select pin levels {bit1, bit0}
	localparam logic [6:0] I2C_ADDR_00 = 7'h1E;
	localparam logic [6:0] I2C_ADDR_01 = 7'h1D;
	localparam logic [6:0] I2C_ADDR_10 = 7'h1C;
	localparam logic [6:0] I2C_ADDR_11 = 7'h1F;

	// ==========================================
	// Direction bit encodings
	localparam logic I2C_DIR_READ = 1'h1;
	localparam logic SPI_DIR_READ = 1'h0;
	localparam logic SPI_DIR_WRITE = 1'h1;

	// ==========================================
	// Framing
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [1:0] SPI_HDR0 = 2'h0;
	localparam logic [1:0] SPI_HDR1 = 2'h1;
	localparam logic [1:0] SPI_DATA = 2'h2;

	// ==========================================
	// Synchroniser bit positions
	localparam int SY_SCL = 0;
	localparam int SY_SDA = 1;
	localparam int SY_SEL1 = 2;
	localparam int SY_SEL0 = 3;
	localparam int SY_FLOAT = 4;
	localparam int SY_CORE = 5;
	localparam int SY_WIDTH = 6;

	// ==========================================
	// I2C engine states, one-hot
	typedef enum logic [6:0] {
		I2C_IDLE = 7'h01,
		I2C_ADDR = 7'h02,
		I2C_INDEX = 7'h04,
		I2C_WRITE = 7'h08,
		I2C_ACK = 7'h10,
		I2C_READ = 7'h20,
		I2C_MACK = 7'h40
	} srap_i2c_state_t;
endpackage

// [src/srap_spi_link.sv]
// SPI slave engine clocked by the link's serial clock
`timescale 1ns/1ps
module srap_spi_link (
	// Link clock and frame control
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic link_off,
	// Serial data
	input wire logic mosi,
	output logic miso,
	output logic miso_oe_n,
	// Requests toward the system clock domain
	output logic wr_tgl,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic rd_tgl,
	output logic [7:0] rd_addr,
	// Read data held stable by the system clock domain
	input wire logic [7:0] rd_data
);
	logic frame_rst;
	logic [2:0] bit_cnt;
	logic [1:0] byte_idx;
	logic [7:0] sin;
	logic [7:0] next_sin;
	logic rw;
	logic [7:0] addr;
	logic [7:0] sout;

	// Frame abort on deselect
	// Chip select high clears all frame state at once, the clock may stop any time
	assign frame_rst = cs_n | link_off;
	assign next_sin = {sin[6:0], mosi};
	assign miso = sout[7];

	// ==========================================
	// Header and address tracking, sampled on the rising edge
	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt <= 3'h0;
			byte_idx <= srap_pkg::SPI_HDR0;
			sin <= 8'h00;
			rw <= srap_pkg::SPI_DIR_READ;
			addr <= 8'h00;
		end else begin
			sin <= next_sin;
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == srap_pkg::LAST_BIT) begin
				if (byte_idx != srap_pkg::SPI_DATA) begin
					byte_idx <= byte_idx + 2'h1;
				end
				case (byte_idx)
					srap_pkg::SPI_HDR0: begin
						rw <= next_sin[7];
						addr[6:0] <= next_sin[6:0];
					end
					srap_pkg::SPI_HDR1: begin
						addr[7] <= sin[6];
					end
					default: begin
						addr <= addr + 8'h01;
					end
				endcase
			end
		end
	end

	// ==========================================
	// Requests; toggles survive frame ends so the far side never sees a false event
	always_ff @(posedge sclk or posedge link_off) begin
		if (link_off) begin
			wr_tgl <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
			rd_tgl <= 1'b0;
			rd_addr <= 8'h00;
		end else begin
			if (rw == srap_pkg::SPI_DIR_WRITE && byte_idx == srap_pkg::SPI_DATA
				&& bit_cnt == srap_pkg::LAST_BIT) begin
				wr_addr <= addr;
				wr_data <= next_sin;
				wr_tgl <= ~wr_tgl;
			end
			// Read fetch prefetched a full byte early
			if (rw == srap_pkg::SPI_DIR_READ && bit_cnt == 3'h0) begin
				if (byte_idx == srap_pkg::SPI_HDR1) begin
					rd_addr <= {mosi, addr[6:0]};
					rd_tgl <= ~rd_tgl;
				end else if (byte_idx == srap_pkg::SPI_DATA) begin
					rd_addr <= rd_addr + 8'h01;
					rd_tgl <= ~rd_tgl;
				end
			end
		end
	end

	// ==========================================
	// Read data out; rd_data has been stable for several serial clocks when loaded
	// Shift register contents on MISO
	always_ff @(negedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			sout <= 8'h00;
			miso_oe_n <= 1'b1;
		end else if (rw == srap_pkg::SPI_DIR_READ && byte_idx == srap_pkg::SPI_DATA) begin
			miso_oe_n <= 1'b0;
			if (bit_cnt == 3'h0) begin
				sout <= rd_data;
			end else begin
				sout <= {sout[6:0], 1'b0};
			end
		end
	end
endmodule // srap_spi_link

// [src/srap_serial_port.sv]
// Serial register access port: protocol select, I2C slave, SPI crossing, register port
`timescale 1ns/1ps
module srap_serial_port (
	// System clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Shared serial pins; addr_sel_bit1_pin doubles as SPI chip select, active low
	input wire logic serial_clk,
	input wire logic sdi_pin,
	output logic sda_oe_n,
	input wire logic addr_sel_bit1_pin,
	input wire logic addr_sel_bit0_pin,
	input wire logic addr_sel_bit0_float,
	output logic miso,
	output logic miso_oe_n,
	// Power status and factory trim
	input wire logic core_supply_ok,
	input wire logic trim_force_en,
	input wire logic trim_force_spi,
	// Internal register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Status
	output logic spi_mode
);
	logic [srap_pkg::SY_WIDTH-1:0] sync_a;
	logic [srap_pkg::SY_WIDTH-1:0] sync_b;
	logic scl_s;
	logic sda_s;
	logic core_ok_s;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic proto_set;
	logic proto_spi;
	logic i2c_on;
	logic spi_off;
	srap_pkg::srap_i2c_state_t i2c_state;
	srap_pkg::srap_i2c_state_t i2c_after;
	logic [3:0] i2c_cnt;
	logic [7:0] i2c_rx;
	logic [7:0] next_rx;
	logic [7:0] i2c_tx;
	logic [7:0] i2c_ptr;
	logic [7:0] i2c_req_addr;
	logic [7:0] i2c_wdata;
	logic i2c_wr_req;
	logic i2c_rd_req;
	logic [6:0] own_addr;
	logic spi_wr_tgl;
	logic spi_rd_tgl;
	logic [7:0] spi_wr_addr;
	logic [7:0] spi_wr_data;
	logic [7:0] spi_rd_addr;
	logic [1:0] tg_a;
	logic [1:0] tg_b;
	logic [1:0] tg_q;
	logic spi_wr_evt;
	logic spi_rd_evt;
	logic rd_pend;
	logic [7:0] rd_hold;

	function automatic logic [6:0] pick_addr(input logic sel1, input logic sel0);
		case ({sel1, sel0})
			2'b00: pick_addr = srap_pkg::I2C_ADDR_00;
			2'b01: pick_addr = srap_pkg::I2C_ADDR_01;
			2'b10: pick_addr = srap_pkg::I2C_ADDR_10;
			default: pick_addr = srap_pkg::I2C_ADDR_11;
		endcase
	endfunction

	// ==========================================
	// Pin synchronisers; data only, so no reset is needed
	always_ff @(posedge clk) begin
		sync_a <= {core_supply_ok, addr_sel_bit0_float, addr_sel_bit0_pin,
			addr_sel_bit1_pin, sdi_pin, serial_clk};
		sync_b <= sync_a;
	end

	assign scl_s = sync_b[srap_pkg::SY_SCL];
	assign sda_s = sync_b[srap_pkg::SY_SDA];
	assign core_ok_s = sync_b[srap_pkg::SY_CORE];
	assign own_addr = pick_addr(sync_b[srap_pkg::SY_SEL1], sync_b[srap_pkg::SY_SEL0]);
	assign next_rx = {i2c_rx[6:0], sda_s};

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_seen = scl_s & scl_q & ~sda_q & sda_s;

	// ==========================================
	// Protocol selection, taken once after reset release
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			proto_set <= 1'b0;
			proto_spi <= 1'b0;
		end else if (!proto_set && core_ok_s) begin
			proto_set <= 1'b1;
			proto_spi <= trim_force_en ? trim_force_spi : sync_b[srap_pkg::SY_FLOAT];
		end
	end

	// Links held off without core supply
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			i2c_on <= 1'b0;
			spi_off <= 1'b1;
			spi_mode <= 1'b0;
		end else begin
			i2c_on <= proto_set & ~proto_spi & core_ok_s;
			spi_off <= ~(proto_set & proto_spi & core_ok_s);
			spi_mode <= proto_set & proto_spi;
		end
	end

	// ==========================================
	// I2C slave engine, oversampled on the system clock
	// There is no clock line driver, so stretching cannot happen
	always_ff @(posedge clk) begin
		if (sys_rst || !i2c_on) begin
			i2c_state <= srap_pkg::I2C_IDLE;
			i2c_after <= srap_pkg::I2C_IDLE;
			i2c_cnt <= 4'h0;
			i2c_rx <= 8'h00;
			i2c_tx <= 8'h00;
			i2c_ptr <= 8'h00;
			i2c_req_addr <= 8'h00;
			i2c_wdata <= 8'h00;
			i2c_wr_req <= 1'b0;
			i2c_rd_req <= 1'b0;
			sda_oe_n <= 1'b1;
		end else begin
			i2c_wr_req <= 1'b0;
			i2c_rd_req <= 1'b0;
			if (stop_seen) begin
				i2c_state <= srap_pkg::I2C_IDLE;
				sda_oe_n <= 1'b1;
			end else if (start_seen) begin
				i2c_state <= srap_pkg::I2C_ADDR;
				i2c_cnt <= 4'h0;
				sda_oe_n <= 1'b1;
			end else if (scl_rise) begin
				case (i2c_state)
					srap_pkg::I2C_ADDR, srap_pkg::I2C_INDEX, srap_pkg::I2C_WRITE: begin
						i2c_rx <= next_rx;
						i2c_cnt <= i2c_cnt + 4'h1;
					end
					srap_pkg::I2C_READ: begin
						i2c_cnt <= i2c_cnt + 4'h1;
					end
					srap_pkg::I2C_MACK: begin
						if (!sda_s) begin
							i2c_ptr <= i2c_ptr + 8'h01;
							i2c_req_addr <= i2c_ptr + 8'h01;
							i2c_rd_req <= 1'b1;
							i2c_after <= srap_pkg::I2C_READ;
							i2c_state <= srap_pkg::I2C_ACK;
						end else begin
							i2c_state <= srap_pkg::I2C_IDLE;
						end
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (i2c_state)
					srap_pkg::I2C_ADDR: begin
						if (i2c_cnt == srap_pkg::BYTE_BITS) begin
							if (i2c_rx[7:1] == own_addr) begin
								sda_oe_n <= 1'b0;
								i2c_state <= srap_pkg::I2C_ACK;
								if (i2c_rx[0] == srap_pkg::I2C_DIR_READ) begin
									i2c_after <= srap_pkg::I2C_READ;
									i2c_req_addr <= i2c_ptr;
									i2c_rd_req <= 1'b1;
								end else begin
									i2c_after <= srap_pkg::I2C_INDEX;
								end
							end else begin
								i2c_state <= srap_pkg::I2C_IDLE;
							end
						end
					end
					srap_pkg::I2C_INDEX: begin
						if (i2c_cnt == srap_pkg::BYTE_BITS) begin
							i2c_ptr <= i2c_rx;
							sda_oe_n <= 1'b0;
							i2c_state <= srap_pkg::I2C_ACK;
							i2c_after <= srap_pkg::I2C_WRITE;
						end
					end
					srap_pkg::I2C_WRITE: begin
						if (i2c_cnt == srap_pkg::BYTE_BITS) begin
							i2c_req_addr <= i2c_ptr;
							i2c_wdata <= i2c_rx;
							i2c_wr_req <= 1'b1;
							i2c_ptr <= i2c_ptr + 8'h01;
							sda_oe_n <= 1'b0;
							i2c_state <= srap_pkg::I2C_ACK;
							i2c_after <= srap_pkg::I2C_WRITE;
						end
					end
					// End of acknowledge clock; a read puts its first bit out here
					srap_pkg::I2C_ACK: begin
						i2c_cnt <= 4'h0;
						i2c_state <= i2c_after;
						if (i2c_after == srap_pkg::I2C_READ) begin
							sda_oe_n <= rd_hold[7];
							i2c_tx <= {rd_hold[6:0], 1'b1};
						end else begin
							sda_oe_n <= 1'b1;
						end
					end
					srap_pkg::I2C_READ: begin
						if (i2c_cnt == srap_pkg::BYTE_BITS) begin
							sda_oe_n <= 1'b1;
							i2c_state <= srap_pkg::I2C_MACK;
						end else begin
							sda_oe_n <= i2c_tx[7];
							i2c_tx <= {i2c_tx[6:0], 1'b1};
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ==========================================
	// SPI engine on the link clock
	// Slave only, driven by host clock
	srap_spi_link u_spi (
		.sclk(serial_clk),
		.cs_n(addr_sel_bit1_pin),
		.link_off(spi_off),
		.mosi(sdi_pin),
		.miso(miso),
		.miso_oe_n(miso_oe_n),
		.wr_tgl(spi_wr_tgl),
		.wr_addr(spi_wr_addr),
		.wr_data(spi_wr_data),
		.rd_tgl(spi_rd_tgl),
		.rd_addr(spi_rd_addr),
		.rd_data(rd_hold)
	);

	// Toggle crossing; address and data words stay stable for a whole byte
	always_ff @(posedge clk) begin
		if (sys_rst || spi_off) begin
			tg_a <= 2'h0;
			tg_b <= 2'h0;
			tg_q <= 2'h0;
		end else begin
			tg_a <= {spi_rd_tgl, spi_wr_tgl};
			tg_b <= tg_a;
			tg_q <= tg_b;
		end
	end

	assign spi_wr_evt = tg_b[0] ^ tg_q[0];
	assign spi_rd_evt = tg_b[1] ^ tg_q[1];

	// ==========================================
	// Register port; only one protocol is live, so requests never collide
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_addr <= 8'h00;
			reg_wdata <= 8'h00;
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
		end else begin
			reg_wr <= i2c_wr_req | spi_wr_evt;
			reg_rd <= i2c_rd_req | spi_rd_evt;
			if (i2c_wr_req || i2c_rd_req) begin
				reg_addr <= i2c_req_addr;
				reg_wdata <= i2c_wdata;
			end else if (spi_wr_evt) begin
				reg_addr <= spi_wr_addr;
				reg_wdata <= spi_wr_data;
			end else if (spi_rd_evt) begin
				reg_addr <= spi_rd_addr;
			end
		end
	end

	// Read data captured one cycle after the read strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_pend <= 1'b0;
			rd_hold <= 8'h00;
		end else begin
			rd_pend <= reg_rd;
			if (rd_pend) begin
				rd_hold <= reg_rdata;
			end
		end
	end
endmodule // srap_serial_port

// [verification/srap_serial_port_chk.sv]
// Concurrent checks on the ports of the serial register access port
`timescale 1ns/1ps
module srap_serial_port_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pins and status
	input wire logic addr_sel_bit1_pin,
	input wire logic sda_oe_n,
	input wire logic miso_oe_n,
	input wire logic core_supply_ok,
	input wire logic spi_mode,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// ==========================================
	// Register port strobes
	sequence rd_req_s;
		reg_rd;
	endsequence
	sequence rd_hold_s;
		!reg_rd && $stable(reg_addr);
	endsequence
	rw_excl_a: assert property (!(reg_wr && reg_rd))
		else $error("write and read strobes high together");
	wr_hold_a: assert property (
		reg_wr |=> !reg_wr && $stable(reg_addr) && $stable(reg_wdata))
		else $error("write strobe too long or its address moved");
	rd_hold_a: assert property (rd_req_s |=> rd_hold_s)
		else $error("read address moved while data was due");
	// ==========================================
	// Protocol latch and pin ownership
	mode_hold_a: assert property (spi_mode |=> spi_mode)
		else $error("protocol left SPI without a reset");
	spi_quiet_a: assert property (spi_mode |-> sda_oe_n)
		else $error("data line pulled low in SPI mode");
	i2c_miso_a: assert property (!spi_mode |-> miso_oe_n)
		else $error("serial output driven in I2C mode");
	cs_release_a: assert property (spi_mode && addr_sel_bit1_pin |-> miso_oe_n)
		else $error("serial output driven without chip select");
	core_off_a: assert property (
		!core_supply_ok [*6] |-> sda_oe_n && !reg_wr && !reg_rd)
		else $error("activity while the core supply is absent");
	// Reset itself is the cause here, so it must not disable the check
	rst_quiet_a: assert property (disable iff (1'b0)
		sys_rst |=> sda_oe_n && !reg_wr && !reg_rd && !spi_mode)
		else $error("outputs not quiet after reset");
endmodule // srap_serial_port_chk

bind srap_serial_port srap_serial_port_chk i_chk (
	.clk(clk),
	.sys_rst(sys_rst),
	.addr_sel_bit1_pin(addr_sel_bit1_pin),
	.sda_oe_n(sda_oe_n),
	.miso_oe_n(miso_oe_n),
	.core_supply_ok(core_supply_ok),
	.spi_mode(spi_mode),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd)
);

// [verification/srap_host_model.sv]
// Host bus master model driving the shared serial pins
`timescale 1ns/1ps
module srap_host_model (
	// Device outputs
	input wire logic sda_oe_n,
	input wire logic miso,
	input wire logic miso_oe_n,
	// Host-driven pins
	output logic serial_clk,
	output logic sdi_pin,
	output logic sel1
);
	localparam int I2C_H = 400;
	localparam int SPI_H = 500;
	logic sdo;
	// Open drain with pull-up; the device never pulls in SPI mode
	assign sdi_pin = sdo & sda_oe_n;
	initial begin
		serial_clk = 1'b1;
		sdo = 1'b1;
		sel1 = 1'b0;
	end
	// ==========================================
	// I2C master
	task automatic i2c_start();
		sdo = 1'b1;
		#I2C_H serial_clk = 1'b1;
		#I2C_H sdo = 1'b0;
		#I2C_H serial_clk = 1'b0;
	endtask
	task automatic i2c_stop();
		#(I2C_H / 4) sdo = 1'b0;
		#I2C_H serial_clk = 1'b1;
		#I2C_H sdo = 1'b1;
		#I2C_H;
	endtask
	// clock low time set by host alone
	task automatic i2c_bit(input logic b, output logic r);
		#(I2C_H / 4) sdo = b;
		#(I2C_H * 3 / 4) serial_clk = 1'b1;
		#(I2C_H / 2) r = sdi_pin;
		#(I2C_H / 2) serial_clk = 1'b0;
	endtask
	task automatic i2c_byte(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
		i2c_bit(mack, ack);
	endtask
	// ==========================================
	// SPI master, clock idles low outside frames
	// frame framed by chip select
	task automatic spi_cs(input logic v);
		serial_clk = 1'b0;
		#SPI_H sel1 = v;
		#SPI_H;
	endtask
	// MSB first, change low, sample on rise
	task automatic spi_bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			sdo = tx[i];
			#SPI_H serial_clk = 1'b1;
			rx[i] = miso_oe_n ? ~miso : miso;
			#SPI_H serial_clk = 1'b0;
		end
	endtask
endmodule // srap_host_model

// [verification/tb.sv]
// Self-checking testbench of the serial register access port
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic sel0;
	logic sel0_float;
	logic core_ok;
	logic trim_en;
	logic trim_spi;
	logic [7:0] reg_rdata;
	logic serial_clk, sdi_pin, sel1, sda_oe_n, miso, miso_oe_n, reg_wr, reg_rd, spi_mode;
	logic [7:0] reg_addr, reg_wdata;
	logic [7:0] mem [256];
	int error_cnt = 0;
	int comparisons = 0;
	always #20 clk = ~clk;
	assign reg_rdata = mem[reg_addr];
	always @(posedge clk) if (reg_wr) mem[reg_addr] <= reg_wdata;
	srap_host_model host (.sda_oe_n(sda_oe_n), .miso(miso), .miso_oe_n(miso_oe_n),
		.serial_clk(serial_clk), .sdi_pin(sdi_pin), .sel1(sel1));
	srap_serial_port i_srap_serial_port (.clk(clk), .sys_rst(sys_rst),
		.serial_clk(serial_clk), .sdi_pin(sdi_pin), .sda_oe_n(sda_oe_n),
		.addr_sel_bit1_pin(sel1), .addr_sel_bit0_pin(sel0), .addr_sel_bit0_float(sel0_float),
		.miso(miso), .miso_oe_n(miso_oe_n), .core_supply_ok(core_ok),
		.trim_force_en(trim_en), .trim_force_spi(trim_spi), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.spi_mode(spi_mode));
	// ==========================================
	// Reporting
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic do_reset(input logic fl, input logic ten, input logic tsp, input logic exp);
		@(posedge clk) #2 sys_rst = 1'b1;
		sel0_float = fl;
		trim_en = ten;
		trim_spi = tsp;
		repeat (20) @(posedge clk);
		#2 sys_rst = 1'b0;
		repeat (8) @(posedge clk);
		chk("spi_mode", {7'h0, exp}, {7'h0, spi_mode});
	endtask
	// ==========================================
	// I2C scenarios, select pins 00 except the 01 pass in t_i2c_other
	task automatic i2c_wr(input logic [6:0] dev, input logic [7:0] idx, input logic [7:0] d,
		output logic [2:0] acks);
		logic [7:0] rx;
		host.i2c_start();
		host.i2c_byte({dev, 1'b0}, 1'b1, rx, acks[2]);
		host.i2c_byte(idx, 1'b1, rx, acks[1]);
		host.i2c_byte(d, 1'b1, rx, acks[0]);
	endtask
	task automatic t_i2c_write();
		logic [7:0] rx;
		logic [2:0] a;
		logic a3;
		i2c_wr(7'h1e, 8'h10, 8'ha5, a);
		host.i2c_byte(8'h3c, 1'b1, rx, a3);
		host.i2c_stop();
		chk("i2c_acks", 8'h00, {4'h0, a, a3});
		chk("mem_10", 8'ha5, mem[8'h10]);
		chk("mem_11", 8'h3c, mem[8'h11]);
	endtask
	task automatic t_i2c_read();
		logic [7:0] rx, d0, d1;
		logic [2:0] a;
		logic x;
		i2c_wr(7'h1e, 8'h11, 8'h5a, a);
		host.i2c_stop();
		host.i2c_start();
		host.i2c_byte({7'h1e, 1'b0}, 1'b1, rx, a[2]);
		host.i2c_byte(8'h10, 1'b1, rx, a[1]);
		host.i2c_start();
		host.i2c_byte({7'h1e, 1'b1}, 1'b1, rx, a[0]);
		host.i2c_byte(8'hff, 1'b0, d0, x);
		host.i2c_byte(8'hff, 1'b1, d1, x);
		host.i2c_stop();
		chk("rd_acks", 8'h00, {5'h0, a});
		chk("rd_byte0", 8'ha5, d0);
		chk("rd_byte1", 8'h5a, d1);
	endtask
	task automatic t_i2c_other();
		logic [2:0] a;
		i2c_wr(7'h1d, 8'h20, 8'h66, a);
		host.i2c_stop();
		chk("other_addr", 8'h07, {5'h0, a});
		chk("mem_20", 8'h00, mem[8'h20]);
		// Select pin 0 high moves the own address to the 01 entry
		@(posedge clk) #2 sel0 = 1'b1;
		repeat (4) @(posedge clk);
		i2c_wr(7'h1d, 8'h21, 8'h67, a);
		host.i2c_stop();
		chk("sel0_acks", 8'h00, {5'h0, a});
		chk("mem_21", 8'h67, mem[8'h21]);
		@(posedge clk) #2 sel0 = 1'b0;
		repeat (4) @(posedge clk);
		@(posedge clk) #2 sel0_float = 1'b1;
		repeat (10) @(posedge clk);
		chk("mode_held", 8'h00, {7'h0, spi_mode});
		#2 sel0_float = 1'b0;
	endtask
	task automatic t_core_off();
		logic [2:0] a;
		@(posedge clk) #2 core_ok = 1'b0;
		i2c_wr(7'h1e, 8'h30, 8'h77, a);
		host.i2c_stop();
		chk("core_off_ack", 8'h07, {5'h0, a});
		chk("mem_30", 8'h00, mem[8'h30]);
		@(posedge clk) #2 core_ok = 1'b1;
	endtask
	// ==========================================
	// SPI scenarios
	task automatic t_spi_write();
		logic [7:0] rx;
		host.spi_cs(1'b0);
		host.spi_bits({1'b1, 7'h42}, 8, rx);
		host.spi_bits({1'b1, 7'h55}, 8, rx);
		host.spi_bits(8'h11, 8, rx);
		host.spi_bits(8'h22, 8, rx);
		host.spi_bits(8'h33, 8, rx);
		host.spi_cs(1'b1);
		chk("mem_c2", 8'h11, mem[8'hc2]);
		chk("mem_c3", 8'h22, mem[8'hc3]);
		chk("mem_c4", 8'h33, mem[8'hc4]);
	endtask
	task automatic t_spi_read(input logic [7:0] a, input int n, input logic [23:0] exp);
		logic [7:0] rx;
		host.spi_cs(1'b0);
		host.spi_bits({1'b0, a[6:0]}, 8, rx);
		host.spi_bits({a[7], 7'h7f}, 8, rx);
		for (int i = 0; i < n; i++) begin
			host.spi_bits(8'hff, 8, rx);
			chk("spi_rd", exp[23 - 8 * i -: 8], rx);
		end
		host.spi_cs(1'b1);
		chk("miso_oe_n", 8'h01, {7'h0, miso_oe_n});
	endtask
	task automatic t_spi_abort();
		logic [7:0] rx;
		host.spi_cs(1'b0);
		host.spi_bits({1'b1, 7'h50}, 8, rx);
		host.spi_bits(8'h00, 8, rx);
		host.spi_bits(8'h99, 4, rx);
		host.spi_cs(1'b1);
		chk("mem_50", 8'h00, mem[8'h50]);
		t_spi_read(8'hc3, 1, 24'h22_0000);
	endtask
	initial begin
		#3_000_000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		sel0 = 1'b0;
		sel0_float = 1'b0;
		core_ok = 1'b1;
		trim_en = 1'b0;
		trim_spi = 1'b0;
		for (int i = 0; i < 256; i++) mem[i] = 8'h00;
		do_reset(1'b0, 1'b0, 1'b0, 1'b0);
		t_i2c_write();
		t_i2c_read();
		t_i2c_other();
		t_core_off();
		host.spi_cs(1'b1);
		do_reset(1'b1, 1'b1, 1'b0, 1'b0);
		do_reset(1'b0, 1'b1, 1'b1, 1'b1);
		do_reset(1'b1, 1'b0, 1'b0, 1'b1);
		t_spi_write();
		t_spi_read(8'hc2, 3, 24'h11_2233);
		t_spi_abort();
		wrap_up();
	end
endmodule // tb
